// *** sync_mem_pkg.sv ***
// shared constants and carrier types for the synchronous memory port
package sync_mem_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;
  localparam int SLOT_W = 3;
  localparam int LAT_W  = 2;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_SPACE_SEC = 8'h00;
  localparam logic [7:0] OFS_ACC_ADDR  = 8'h04;
  localparam logic [7:0] OFS_WR_DATA   = 8'h08;
  localparam logic [7:0] OFS_ACC_CMD   = 8'h0c;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_RD_DATA   = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int SEC_RL_LSB  = 0;
  localparam int SEC_WL_LSB  = 2;
  localparam int SEC_CHIP_ENABLE_EXTEND   = 4;
  localparam int SEC_STROBE  = 5;
  localparam int SEC_CLKSEL  = 6;
  localparam int SEC_W       = 7;
  localparam int CMD_WRITE   = 0;
  localparam int CMD_BE_LSB  = 4;
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_REFUSED  = 2;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and slot numbers
  localparam logic [SEC_W-1:0]  SEC_RESET   = 7'h00;
  localparam logic [BE_W-1:0]   BE_RESET    = 4'hf;
  localparam logic [SLOT_W-1:0] SLOT_CMD    = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_DATA0  = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_DESEL  = 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // carrier types
  typedef struct packed {
    logic             clk_sel;
    logic             strobe_fn;
    logic             ce_ext;
    logic [LAT_W-1:0] wr_lat;
    logic [LAT_W-1:0] rd_lat;
  } space_cfg_s;

  typedef struct packed {
    logic              is_write;
    logic [BE_W-1:0]   be;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } access_s;

  typedef struct packed {
    logic            ce_n;
    logic            strobe_a_n;
    logic            strobe_b_n;
    logic            strobe_c_n;
    logic [BE_W-1:0] be_n;
    logic            data_oe;
  } pin_ctl_s;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_RUN    = 3'b010,
    ST_FINISH = 3'b100
  } seq_state_e;

endpackage

// *** bit_sync.sv ***
// two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule // bit_sync

// *** programmable_sync_mem_port.sv ***
// programmable synchronous memory port: wishbone registers and link sequencer
// Operation
// [RULE_01] each access reads with a latency of zero to three memory clock cycles.
// [RULE_02] each access writes data zero to three memory clock cycles after the command.
// [RULE_03] with extension off, chip enable drops once the last command is issued.
// [RULE_04] with extension on, chip enable stays low as long as output enable is low.
// [RULE_05] with strobe function clear, the strobe is an address strobe with deselect cycles; reads with extension on get no deselect cycle.
// [RULE_06] with strobe function set, the strobe is a fifo read enable with no deselect.
// [RULE_07] all pins and sampling follow one of two output clocks picked by the select bit.
// [RULE_08] the three shared pins act as strobe, output enable and write enable.
// [RULE_09] read data is captured exactly the read latency after the data slot.
// [RULE_10] the memory presents and accepts data on the slots the latencies imply.
`timescale 1ns/1ps
module programmable_sync_mem_port (
  // system clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  // wishbone slave
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [7:0]                        wb_adr_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic [31:0]                       wb_dat_i,
  output logic      [31:0]                       wb_dat_o,
  output logic                                   wb_ack_o,
  // link clock and memory clocks out
  input  wire logic                              link_clk_i,
  output logic                                   mem_out_clock_a_o,
  output logic                                   mem_out_clock_b_o,
  // memory pins
  output logic                                   space_chip_enable_n_o,
  output logic                                   shared_strobe_pin_a_n_o,
  output logic                                   shared_strobe_pin_b_n_o,
  output logic                                   shared_strobe_pin_c_n_o,
  output logic      [sync_mem_pkg::BE_W-1:0]     byte_enable_n_o,
  output logic      [sync_mem_pkg::ADDR_W-1:0]   mem_addr_o,
  output logic      [sync_mem_pkg::DATA_W-1:0]   mem_data_o,
  output logic                                   mem_data_oe_o,
  input  wire logic [sync_mem_pkg::DATA_W-1:0]   mem_data_i
);

  ////////////////////////////////////////////////////////////////////////////
  // system domain registers
  sync_mem_pkg::space_cfg_s               space_secondary_control_r;
  sync_mem_pkg::access_s                  acc_r;
  logic [sync_mem_pkg::DATA_W-1:0]        rd_data_r;
  logic [sync_mem_pkg::DATA_W-1:0]        link_rdata_r;
  logic                                   busy_r;
  logic                                   done_r;
  logic                                   refused_r;
  logic                                   req_tgl_r;
  logic                                   done_seen_r;
  logic                                   done_sync;
  logic                                   done_evt;
  logic                                   wb_req;
  logic                                   wb_wr;
  logic                                   start_cmd;
  logic [31:0]                            rd_mux;

  assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr     = wb_req & wb_we_i;
  assign start_cmd = wb_wr & (wb_adr_i == sync_mem_pkg::OFS_ACC_CMD) & wb_sel_i[0] & ~busy_r;
  assign done_evt  = done_sync ^ done_seen_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req & ~wb_we_i ? rd_mux : '0;
    end
  end

  always_comb begin
    rd_mux = '0;
    case (wb_adr_i)
      sync_mem_pkg::OFS_SPACE_SEC: rd_mux[sync_mem_pkg::SEC_W-1:0] = space_secondary_control_r;
      sync_mem_pkg::OFS_ACC_ADDR:  rd_mux[sync_mem_pkg::ADDR_W-1:0] = acc_r.addr;
      sync_mem_pkg::OFS_WR_DATA:   rd_mux = acc_r.wdata;
      sync_mem_pkg::OFS_ACC_CMD: begin
        rd_mux[sync_mem_pkg::CMD_WRITE] = acc_r.is_write;
        rd_mux[sync_mem_pkg::CMD_BE_LSB +: sync_mem_pkg::BE_W] = acc_r.be;
      end
      sync_mem_pkg::OFS_STATUS: begin
        rd_mux[sync_mem_pkg::ST_BUSY]    = busy_r;
        rd_mux[sync_mem_pkg::ST_DONE]    = done_r;
        rd_mux[sync_mem_pkg::ST_REFUSED] = refused_r;
      end
      sync_mem_pkg::OFS_RD_DATA:   rd_mux = rd_data_r;
      default:                     rd_mux = '0;
    endcase
  end

  // config and access fields held still while busy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      space_secondary_control_r <= sync_mem_pkg::SEC_RESET;
      acc_r                     <= '0;
      acc_r.be                  <= sync_mem_pkg::BE_RESET;
    end else if (wb_wr & ~busy_r) begin
      case (wb_adr_i)
        sync_mem_pkg::OFS_SPACE_SEC: begin
          if (wb_sel_i[0]) begin
            space_secondary_control_r <= wb_dat_i[sync_mem_pkg::SEC_W-1:0];
          end
        end
        sync_mem_pkg::OFS_ACC_ADDR: begin
          if (&wb_sel_i[2:0]) begin
            acc_r.addr <= wb_dat_i[sync_mem_pkg::ADDR_W-1:0];
          end
        end
        sync_mem_pkg::OFS_WR_DATA: begin
          for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) begin
              acc_r.wdata[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
            end
          end
        end
        sync_mem_pkg::OFS_ACC_CMD: begin
          if (wb_sel_i[0]) begin
            acc_r.is_write <= wb_dat_i[sync_mem_pkg::CMD_WRITE];
            acc_r.be       <= wb_dat_i[sync_mem_pkg::CMD_BE_LSB +: sync_mem_pkg::BE_W];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // command handshake toward the link
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_tgl_r   <= 1'b0;
      busy_r      <= 1'b0;
      done_seen_r <= 1'b0;
      rd_data_r   <= '0;
    end else begin
      done_seen_r <= done_sync;
      if (start_cmd) begin
        req_tgl_r <= ~req_tgl_r;
        busy_r    <= 1'b1;
      end else if (done_evt) begin
        busy_r <= 1'b0;
      end
      if (done_evt & ~acc_r.is_write) begin
        rd_data_r <= link_rdata_r;
      end
    end
  end

  // sticky flags, a new event wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_r    <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      if (done_evt) begin
        done_r <= 1'b1;
      end else if (wb_wr & (wb_adr_i == sync_mem_pkg::OFS_STATUS) & wb_sel_i[0]
                   & wb_dat_i[sync_mem_pkg::ST_DONE]) begin
        done_r <= 1'b0;
      end
      if (wb_wr & busy_r) begin
        refused_r <= 1'b1;
      end else if (wb_wr & (wb_adr_i == sync_mem_pkg::OFS_STATUS) & wb_sel_i[0]
                   & wb_dat_i[sync_mem_pkg::ST_REFUSED]) begin
        refused_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // crossings
  logic                                   link_rst;
  logic                                   req_sync;
  logic                                   req_seen_r;
  logic                                   link_done_tgl_r;
  sync_mem_pkg::space_cfg_s               cfg_sync;

  bit_sync #(.W(1)) u_rst_sync (
    .clk_i (link_clk_i),
    .rst_i (1'b0),
    .d_i   (rst_i),
    .q_o   (link_rst)
  );

  bit_sync #(.W(1)) u_req_sync (
    .clk_i (link_clk_i),
    .rst_i (link_rst),
    .d_i   (req_tgl_r),
    .q_o   (req_sync)
  );

  bit_sync #(.W(sync_mem_pkg::SEC_W)) u_cfg_sync (
    .clk_i (link_clk_i),
    .rst_i (link_rst),
    .d_i   (space_secondary_control_r),
    .q_o   (cfg_sync)
  );

  bit_sync #(.W(1)) u_done_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (link_done_tgl_r),
    .q_o   (done_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // link domain: output clocks and step strobe
  sync_mem_pkg::seq_state_e               state_r;
  sync_mem_pkg::space_cfg_s               cfg_l_r;
  sync_mem_pkg::access_s                  acc_l_r;
  sync_mem_pkg::access_s                  acc_cur;
  sync_mem_pkg::pin_ctl_s                 pins_r;
  sync_mem_pkg::pin_ctl_s                 pins_nxt;
  logic [sync_mem_pkg::SLOT_W-1:0]        slot_r;
  logic [sync_mem_pkg::SLOT_W-1:0]        slot_nxt;
  logic [sync_mem_pkg::SLOT_W-1:0]        last_slot;
  logic [sync_mem_pkg::SLOT_W-1:0]        rd_slot;
  logic [sync_mem_pkg::SLOT_W-1:0]        wr_slot;
  logic                                   div_r;
  logic                                   step;
  logic                                   req_evt;

  assign mem_out_clock_a_o = link_clk_i;
  assign mem_out_clock_b_o = div_r;
  assign req_evt           = req_sync ^ req_seen_r;
  // command slot is built before the access is latched, so read it live
  assign acc_cur           = (state_r == sync_mem_pkg::ST_IDLE) ? acc_r : acc_l_r;
  // clock b rises at the edges where div_r leaves zero
  assign step = ~cfg_l_r.clk_sel | ~div_r;                               // [RULE_07]

  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      div_r <= 1'b0;
    end else begin
      div_r <= ~div_r;
    end
  end

  // read data slot: one past the command plus rd_lat; write data slot: the command slot plus wr_lat
  assign rd_slot   = sync_mem_pkg::SLOT_DATA0 + {1'b0, cfg_l_r.rd_lat};  // [RULE_01]
  assign wr_slot   = {1'b0, cfg_l_r.wr_lat};                             // [RULE_02]
  assign last_slot = acc_l_r.is_write ?
                     ((wr_slot > sync_mem_pkg::SLOT_DESEL) ? wr_slot : sync_mem_pkg::SLOT_DESEL)
                     : rd_slot;

  ////////////////////////////////////////////////////////////////////////////
  // pin pattern for the slot about to be driven
  always_comb begin
    logic rd_oe;
    rd_oe    = 1'b0;
    slot_nxt = slot_r + 3'h1;
    pins_nxt = '1;
    pins_nxt.data_oe = 1'b0;
    if (state_r == sync_mem_pkg::ST_IDLE) begin
      slot_nxt = sync_mem_pkg::SLOT_CMD;
    end
    if ((state_r == sync_mem_pkg::ST_IDLE && req_evt) ||
        (state_r == sync_mem_pkg::ST_RUN && slot_r != last_slot)) begin
      rd_oe = ~acc_cur.is_write & (slot_nxt >= sync_mem_pkg::SLOT_DATA0)
              & (slot_nxt <= rd_slot);
      // three shared pins carry strobe, output enable and write enable
      pins_nxt.strobe_b_n = ~rd_oe;                                       // [RULE_08]
      pins_nxt.strobe_c_n = ~(acc_cur.is_write & slot_nxt == sync_mem_pkg::SLOT_CMD);
      pins_nxt.ce_n = ~((slot_nxt == sync_mem_pkg::SLOT_CMD)              // [RULE_03]
                        | (cfg_l_r.ce_ext & rd_oe));                      // [RULE_04]
      if (!cfg_l_r.strobe_fn) begin
        // address strobe, then a deselect cycle with chip enable high, except on reads with extension on
        pins_nxt.strobe_a_n = ~((slot_nxt == sync_mem_pkg::SLOT_CMD) |    // [RULE_05]
                                (slot_nxt == sync_mem_pkg::SLOT_DESEL & pins_nxt.ce_n));
      end else begin
        // read enable for the fifo, never a deselect
        pins_nxt.strobe_a_n = ~(~acc_cur.is_write &                       // [RULE_06]
                                slot_nxt == sync_mem_pkg::SLOT_CMD);
      end
      pins_nxt.data_oe = acc_cur.is_write & (slot_nxt == wr_slot);        // [RULE_02]
      pins_nxt.be_n    = (slot_nxt == sync_mem_pkg::SLOT_CMD) |
                         (acc_cur.is_write ? slot_nxt == wr_slot : rd_oe) ?
                         ~acc_cur.be : '1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link sequencer
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      state_r         <= sync_mem_pkg::ST_IDLE;
      slot_r          <= sync_mem_pkg::SLOT_CMD;
      req_seen_r      <= 1'b0;
      link_done_tgl_r <= 1'b0;
      cfg_l_r         <= sync_mem_pkg::SEC_RESET;
      acc_l_r         <= '0;
      link_rdata_r    <= '0;
    end else begin
      case (state_r)
        sync_mem_pkg::ST_IDLE: begin
          if (!req_evt) begin
            cfg_l_r <= cfg_sync;
          end else if (step) begin
            // access fields held still by the system side while busy
            acc_l_r    <= acc_r;
            req_seen_r <= req_sync;
            slot_r     <= slot_nxt;
            state_r    <= sync_mem_pkg::ST_RUN;
          end
        end
        sync_mem_pkg::ST_RUN: begin
          if (step) begin
            // memory presents data through the slot, sampled at its end
            if (!acc_l_r.is_write && slot_r == rd_slot) begin
              link_rdata_r <= mem_data_i;                                 // [RULE_09] [RULE_10]
            end
            if (slot_r == last_slot) begin
              state_r <= sync_mem_pkg::ST_FINISH;
            end else begin
              slot_r <= slot_nxt;
            end
          end
        end
        sync_mem_pkg::ST_FINISH: begin
          link_done_tgl_r <= ~link_done_tgl_r;
          state_r         <= sync_mem_pkg::ST_IDLE;
        end
        default: begin
          state_r <= sync_mem_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // pins update only on edges of the selected clock
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      pins_r       <= '1;
      pins_r.data_oe <= 1'b0;
      mem_addr_o   <= '0;
      mem_data_o   <= '0;
    end else if (step) begin                                              // [RULE_07]
      pins_r <= pins_nxt;
      if (state_r == sync_mem_pkg::ST_IDLE && req_evt) begin
        mem_addr_o <= acc_r.addr;
        mem_data_o <= acc_r.wdata;
      end
    end
  end

  assign space_chip_enable_n_o   = pins_r.ce_n;
  assign shared_strobe_pin_a_n_o = pins_r.strobe_a_n;
  assign shared_strobe_pin_b_n_o = pins_r.strobe_b_n;
  assign shared_strobe_pin_c_n_o = pins_r.strobe_c_n;
  assign byte_enable_n_o         = pins_r.be_n;
  assign mem_data_oe_o           = pins_r.data_oe;

endmodule // programmable_sync_mem_port

// *** sync_mem_port_asserts.sv ***
// concurrent checks on the memory port pins and register bus
`timescale 1ns/1ps
module sync_mem_port_asserts (
  // system side
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // link side
  input wire logic        link_clk_i,
  input wire logic        mem_out_clock_b_o,
  input wire logic        space_chip_enable_n_o,
  input wire logic        shared_strobe_pin_a_n_o,
  input wire logic        shared_strobe_pin_b_n_o,
  input wire logic        shared_strobe_pin_c_n_o,
  input wire logic        mem_data_oe_o
);
  wire        ce_n = space_chip_enable_n_o;
  wire        a_n  = shared_strobe_pin_a_n_o;
  wire        b_n  = shared_strobe_pin_b_n_o;
  wire        c_n  = shared_strobe_pin_c_n_o;
  logic [6:0] cfg_r;
  logic [5:0] lrst_r;
  logic [3:0] oe_cnt_r;
  logic [3:0] cmd_cnt_r;
  logic       c_q_r;
  logic       lrst;
  //////////////////////////////////////////////////////////////////////////////
  // shadow of the space config and link-side counters
  assign lrst = rst_i | (|lrst_r);
  always_ff @(posedge clk_i)
    if (rst_i) cfg_r <= '0;
    else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]) cfg_r <= wb_dat_i[6:0];
  always_ff @(posedge link_clk_i) lrst_r <= {lrst_r[4:0], rst_i};
  always_ff @(posedge link_clk_i) oe_cnt_r <= b_n ? 4'h0 : oe_cnt_r + 4'h1;
  always_ff @(posedge link_clk_i) c_q_r <= c_n;
  always_ff @(posedge link_clk_i) cmd_cnt_r <= (c_q_r && !c_n) ? 4'h1 : cmd_cnt_r + 4'h1;
  sequence rd_cmd_s;
    !ce_n && !a_n && c_n && b_n;
  endsequence
  sequence desel_s;
    ce_n && !a_n;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  // assertions
  ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("bus request not answered");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  unmapped_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && wb_adr_i > 8'h14 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  rd_latency_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    $rose(b_n) |-> oe_cnt_r == ((4'(cfg_r[1:0]) + 4'h1) << cfg_r[6]))
    else $error("output enable length wrong");
  wr_latency_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    $rose(mem_data_oe_o) |-> (cfg_r[3:2] == 2'h0 ? (c_q_r && !c_n)
                                 : cmd_cnt_r == (4'(cfg_r[3:2]) << cfg_r[6])))
    else $error("write data slot wrong");
  ce_drop_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    !cfg_r[4] && !b_n |-> ce_n) else $error("chip enable held without extension");
  ce_extend_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    cfg_r[4] && !b_n |-> !ce_n) else $error("chip enable not extended");
  deselect_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    (cfg_r[6:4] == 3'h0) ##0 rd_cmd_s |=> desel_s) else $error("deselect cycle missing");
  no_deselect_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    cfg_r[5] && !a_n |-> !ce_n) else $error("deselect in read enable mode");
  clk_b_half_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    mem_out_clock_b_o != $past(mem_out_clock_b_o)) else $error("clock b not link half rate");
  pin_roles_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    !c_n |-> !ce_n && b_n) else $error("write enable outside command");
  read_drive_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    !b_n |-> !mem_data_oe_o) else $error("data driven during output enable");
endmodule // sync_mem_port_asserts

bind programmable_sync_mem_port sync_mem_port_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link_clk_i,
  .mem_out_clock_b_o, .space_chip_enable_n_o, .shared_strobe_pin_a_n_o,
  .shared_strobe_pin_b_n_o, .shared_strobe_pin_c_n_o, .mem_data_oe_o);

// *** sync_mem_model.sv ***
// behavioural synchronous memory on the far side of the port
`timescale 1ns/1ps
module sync_mem_model (
  // memory clock
  input  wire logic        clk_i,
  // pins from the port
  input  wire logic        ce_n_i,
  input  wire logic        as_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [3:0]  be_n_i,
  input  wire logic [19:0] addr_i,
  input  wire logic [31:0] data_i,
  input  wire logic        data_oe_i,
  output logic      [31:0] data_o
);
  logic [31:0] mem_r [8];
  logic [31:0] idle_r = 32'h0;
  logic [2:0]  addr_r;
  logic [2:0]  wa;
  assign wa = !we_n_i ? addr_i[2:0] : addr_r;
  // released bus toggles so a stray capture shows
  assign data_o = !oe_n_i ? mem_r[addr_r] : idle_r;
  always_ff @(posedge clk_i) idle_r <= ~idle_r;
  always_ff @(posedge clk_i)
    if (!ce_n_i && oe_n_i && (!as_n_i || !we_n_i)) addr_r <= addr_i[2:0];
  always_ff @(posedge clk_i)
    for (int k = 0; k < 4; k++)
      if (data_oe_i && !be_n_i[k]) mem_r[wa][k*8+:8] <= data_i[k*8+:8];
endmodule // sync_mem_model

// *** tb_programmable_sync_mem_port.sv ***
// self-checking bench for the programmable synchronous memory port
`timescale 1ns/1ps
module tb_programmable_sync_mem_port;
  logic        clk_i, rst_i, link_clk_i, mclk;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, pat;
  logic        ce_n, a_n, b_n, c_n, moe;
  logic [3:0]  be_n;
  logic [19:0] addr;
  logic [31:0] mdo, mdi;
  logic [6:0]  sec;
  int          errors, n_checks;

  programmable_sync_mem_port uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .link_clk_i,
    .mem_out_clock_a_o(mclk), .mem_out_clock_b_o(), .space_chip_enable_n_o(ce_n),
    .shared_strobe_pin_a_n_o(a_n), .shared_strobe_pin_b_n_o(b_n),
    .shared_strobe_pin_c_n_o(c_n), .byte_enable_n_o(be_n), .mem_addr_o(addr),
    .mem_data_o(mdo), .mem_data_oe_o(moe), .mem_data_i(mdi));
  sync_mem_model mem (.clk_i(mclk), .ce_n_i(ce_n), .as_n_i(a_n), .oe_n_i(b_n),
    .we_n_i(c_n), .be_n_i(be_n), .addr_i(addr), .data_i(mdo), .data_oe_i(moe), .data_o(mdi));
  //////////////////////////////////////////////////////////////////////////////
  // clocks and watchdog
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #3.7;
    forever #7.5 link_clk_i = ~link_clk_i;
  end
  initial begin
    #2000000;
    errors++;
    results();
  end
  //////////////////////////////////////////////////////////////////////////////
  // bus tasks
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) errors++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      wb(1'b0, 8'h10, 32'h0);
      n++;
    end while (q[1] !== 1'b1 && n < 100);
    chk("done flag", 32'h2, q & 32'h2);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // tests
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, 8'h00, 32'h0);
    chk("space config reset", 32'h0, q);
    wb(1'b0, 8'h10, 32'h0);
    chk("status reset", 32'h0, q);
    wb(1'b1, 8'h18, 32'hffff_ffff);
    wb(1'b0, 8'h18, 32'h0);
    chk("unmapped read", 32'h0, q);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      sec = {i[2], i[0], i[1], ~i[1:0], i[1:0]};
      pat = 32'h1234_5670 + 32'(i);
      wb(1'b1, 8'h00, {25'h0, sec});
      wb(1'b0, 8'h00, 32'h0);
      chk("space config", {25'h0, sec}, q);
      wb(1'b1, 8'h04, 32'(i));
      wb(1'b1, 8'h08, pat);
      wb(1'b1, 8'h0c, 32'hf1);
      if (i == 5) wb(1'b1, 8'h08, ~pat);
      wait_done();
      if (i == 5) chk("refused flag", 32'h4, q & 32'h4);
      wb(1'b1, 8'h10, 32'h6);
      wb(1'b0, 8'h10, 32'h0);
      chk("status cleared", 32'h0, q);
      wb(1'b1, 8'h0c, 32'hf0);
      wait_done();
      wb(1'b1, 8'h10, 32'h2);
      wb(1'b0, 8'h14, 32'h0);
      chk("read data", pat, q);
      $display("test access %0d done", i);
    end
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, 8'h08, 32'hdead_beef);
    wb(1'b1, 8'h0c, 32'h31);
    wait_done();
    wb(1'b1, 8'h10, 32'h2);
    wb(1'b1, 8'h0c, 32'hf0);
    wait_done();
    wb(1'b1, 8'h10, 32'h2);
    wb(1'b0, 8'h14, 32'h0);
    chk("byte lanes", 32'h1234_beef, q);
    $display("test byte lanes done");
    results();
  end
endmodule // tb_programmable_sync_mem_port
